// ---- dv/vrh_chk.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// bus protocol checker
// ----------------------------------------
module vrh_chk (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [vrh_pkg::ADDR_W-1:0] aw_addr,
   input wire logic [vrh_pkg::LEN_W-1:0] aw_len,
   input wire logic aw_valid,
   input wire logic aw_ready,
   input wire logic [vrh_pkg::DATA_W-1:0] w_data,
   input wire logic w_last,
   input wire logic w_valid,
   input wire logic w_ready,
   input wire logic [vrh_pkg::ID_W-1:0] b_id,
   input wire logic b_valid,
   input wire logic b_ready,
   input wire logic [vrh_pkg::ADDR_W-1:0] ar_addr,
   input wire logic [vrh_pkg::LEN_W-1:0] ar_len,
   input wire logic ar_valid,
   input wire logic ar_ready,
   input wire logic [vrh_pkg::DATA_W-1:0] r_data,
   input wire logic r_last,
   input wire logic r_valid,
   input wire logic r_ready
);
   logic [3:0] w_cnt_q;
   logic [3:0] wl_q;
   logic [3:0] r_cnt_q;
   logic [3:0] rl_q;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // beat counters and latched burst lengths
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         w_cnt_q <= 4'h0;
         wl_q <= 4'h0;
         r_cnt_q <= 4'h0;
         rl_q <= 4'h0;
      end else begin
         if (aw_valid && aw_ready) wl_q <= aw_len;
         if (ar_valid && ar_ready) rl_q <= ar_len;
         if (w_valid && w_ready) w_cnt_q <= w_last ? 4'h0 : w_cnt_q + 4'h1;
         if (r_valid && r_ready) r_cnt_q <= r_last ? 4'h0 : r_cnt_q + 4'h1;
      end
   end
   sequence s_aw_taken; aw_valid && aw_ready; endsequence
   sequence s_ar_taken; ar_valid && ar_ready; endsequence
   sequence s_w_done; w_valid && w_ready && w_last; endsequence
   property p_aw_hold; aw_valid && !aw_ready |=> aw_valid && $stable(aw_addr) && $stable(aw_len); endproperty
   property p_w_hold; w_valid && !w_ready |=> w_valid && $stable(w_data) && $stable(w_last); endproperty
   property p_b_hold; b_valid && !b_ready |=> b_valid && $stable(b_id); endproperty
   property p_ar_hold; ar_valid && !ar_ready |=> ar_valid && $stable(ar_addr) && $stable(ar_len); endproperty
   property p_r_hold; r_valid && !r_ready |=> r_valid && $stable(r_data) && $stable(r_last); endproperty
   property p_w_last; w_valid && !aw_valid |-> w_last == (w_cnt_q == wl_q); endproperty
   property p_r_last; r_valid |-> r_last == (r_cnt_q == rl_q); endproperty
   property p_w_rdy; s_aw_taken |=> w_ready; endproperty
   property p_b_after; s_w_done |=> b_valid; endproperty
   property p_r_after; s_ar_taken |=> r_valid; endproperty
   property p_b_cause; $rose(b_valid) |-> $past(w_valid && w_ready && w_last); endproperty
   property p_r_cause; $rose(r_valid) |-> $past(ar_valid && ar_ready); endproperty
   a_aw_hold: assert property (p_aw_hold) else $error("aw payload moved");
   a_w_hold: assert property (p_w_hold) else $error("w payload moved");
   a_b_hold: assert property (p_b_hold) else $error("b payload moved");
   a_ar_hold: assert property (p_ar_hold) else $error("ar payload moved");
   a_r_hold: assert property (p_r_hold) else $error("r payload moved");
   a_w_last: assert property (p_w_last) else $error("w_last misplaced");
   a_r_last: assert property (p_r_last) else $error("r_last misplaced");
   a_w_rdy: assert property (p_w_rdy) else $error("w_ready late");
   a_b_after: assert property (p_b_after) else $error("b_valid late");
   a_r_after: assert property (p_r_after) else $error("r_valid late");
   a_b_cause: assert property (p_b_cause) else $error("b_valid without last beat");
   a_r_cause: assert property (p_r_cause) else $error("r_valid without request");
endmodule : vrh_chk

// ---- dv/vrh_tb_top.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// bench top: manager and subordinate back to back
// ----------------------------------------
module vrh_tb_top;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cmd_valid_i = 1'b0;
   logic cmd_write_i = 1'b0;
   logic [31:0] cmd_addr_i = 32'h0;
   logic [3:0] cmd_len_i = 4'h0;
   logic [31:0] cmd_data_i = 32'h0;
   logic [3:0] cmd_id_i = 4'h0;
   logic cmd_ready_o, rd_valid_o, rd_last_o, done_o;
   logic [31:0] rd_data_o, wr_count_o, rd_count_o;
   logic cmd_ready_lo, rd_valid_lo, rd_last_lo, done_lo;
   logic [31:0] rd_data_lo, wr_count_lo, rd_count_lo;
   logic [31:0] seed = 32'hf9b6eada;
   logic [31:0] mem [16];
   int n_fail = 0;
   int comparisons = 0;
   int nw = 0;
   int nr = 0;
   vrh_bus_if bus ();
   vrh_bus_if bus_lo ();
   vrh_mgr vrh_mgr_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus), .cmd_valid_i(cmd_valid_i),
      .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i), .cmd_data_i(cmd_data_i),
      .cmd_id_i(cmd_id_i), .cmd_ready_o(cmd_ready_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
      .rd_last_o(rd_last_o), .done_o(done_o));
   vrh_sub vrh_sub_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus), .wr_count_o(wr_count_o),
      .rd_count_o(rd_count_o));
   // second pair on the same commands: read address ready idles low
   vrh_mgr vrh_mgr_lo_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_lo), .cmd_valid_i(cmd_valid_i),
      .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i), .cmd_data_i(cmd_data_i),
      .cmd_id_i(cmd_id_i), .cmd_ready_o(cmd_ready_lo), .rd_data_o(rd_data_lo), .rd_valid_o(rd_valid_lo),
      .rd_last_o(rd_last_lo), .done_o(done_lo));
   vrh_sub #(.AR_IDLE_HIGH(1'b0)) vrh_sub_lo_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_lo),
      .wr_count_o(wr_count_lo), .rd_count_o(rd_count_lo));
   vrh_chk vrh_chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .aw_addr(bus.aw_addr), .aw_len(bus.aw_len),
      .aw_valid(bus.aw_valid), .aw_ready(bus.aw_ready), .w_data(bus.w_data), .w_last(bus.w_last),
      .w_valid(bus.w_valid), .w_ready(bus.w_ready), .b_id(bus.b_id), .b_valid(bus.b_valid),
      .b_ready(bus.b_ready), .ar_addr(bus.ar_addr), .ar_len(bus.ar_len), .ar_valid(bus.ar_valid),
      .ar_ready(bus.ar_ready), .r_data(bus.r_data), .r_last(bus.r_last), .r_valid(bus.r_valid),
      .r_ready(bus.r_ready));
   // clock
   always #5 clk_i = ~clk_i;
   // xorshift source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // compare and count
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // verdict and end of run
   task automatic close_out();
      if (n_fail == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : close_out
   // one command: write or read burst, then wait for done
   task automatic op(input logic wr, input logic [3:0] a, input logic [3:0] l, input logic [31:0] d);
      int beats;
      int beats_lo;
      int k;
      logic seen;
      logic seen_lo;
      beats = 0;
      beats_lo = 0;
      seen = 1'b0;
      seen_lo = 1'b0;
      cmd_write_i <= wr;
      cmd_addr_i <= {26'h0, a, 2'h0};
      cmd_len_i <= l;
      cmd_data_i <= d;
      cmd_id_i <= d[7:4];
      cmd_valid_i <= 1'b1;
      @(posedge clk_i);
      cmd_valid_i <= 1'b0;
      if (wr) for (k = 0; k <= l; k++) mem[a + k] = d + k;
      for (k = 0; k < 300 && !(seen && seen_lo); k++) begin
         @(negedge clk_i);
         if (k == 0) check("cmd_busy", {30'h0, cmd_ready_o, cmd_ready_lo}, 32'h0);
         if (rd_valid_o === 1'b1) begin
            check("rd_data", rd_data_o, mem[a + beats]);
            check("rd_last", {31'h0, rd_last_o}, {31'h0, beats == l});
            beats++;
         end
         if (rd_valid_lo === 1'b1) begin
            check("rd_data_lo", rd_data_lo, mem[a + beats_lo]);
            check("rd_last_lo", {31'h0, rd_last_lo}, {31'h0, beats_lo == l});
            beats_lo++;
         end
         seen = seen || (done_o === 1'b1);
         seen_lo = seen_lo || (done_lo === 1'b1);
      end
      check("done", {31'h0, seen}, 32'h1);
      check("done_lo", {31'h0, seen_lo}, 32'h1);
      check("cmd_ready", {30'h0, cmd_ready_o, cmd_ready_lo}, 32'h3);
      if (!wr) check("beats", beats, l + 1);
      if (!wr) check("beats_lo", beats_lo, l + 1);
      if (wr) check("b_id", {28'h0, bus.b_id}, {28'h0, d[7:4]});
      else check("r_id", {28'h0, bus.r_id}, {28'h0, d[7:4]});
      if (wr) nw++;
      else nr++;
      @(posedge clk_i);
   endtask : op
   // main sequence: fill, corner lengths, random mix
   initial begin
      int i;
      logic [31:0] r;
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      op(1'b1, 4'h0, 4'hf, rnd());
      op(1'b0, 4'h0, 4'hf, 32'h0);
      op(1'b1, 4'hf, 4'h0, rnd());
      op(1'b0, 4'hf, 4'h0, 32'h0);
      for (i = 0; i < 30; i++) begin
         r = rnd();
         op(r[31], 4'((r[11:8] % (5'd16 - r[3:0]))), r[3:0], rnd());
      end
      op(1'b0, 4'h0, 4'hf, 32'h0);
      repeat (3) @(posedge clk_i);
      check("wr_count", wr_count_o, nw);
      check("rd_count", rd_count_o, nr);
      check("wr_count_lo", wr_count_lo, nw);
      check("rd_count_lo", rd_count_lo, nr);
      close_out();
   end
   // watchdog
   initial begin
      #400000;
      n_fail++;
      close_out();
   end
endmodule : vrh_tb_top

// ---- hdl/vrh_beat_cnt.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// burst beat counter: flags the final beat
// ----------------------------------------
module vrh_beat_cnt #(
   parameter int LEN_W = vrh_pkg::LEN_W
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic load_i,
   input wire logic [LEN_W-1:0] len_i,
   input wire logic step_i,
   output logic last_o
);
   logic [LEN_W-1:0] cnt_q, cnt_d;

   // load length, count down per beat
   always_comb begin
      cnt_d = cnt_q;
      if (load_i) begin
         cnt_d = len_i;
      end else if (step_i && cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign last_o = (cnt_q == '0); // registered count only
endmodule : vrh_beat_cnt

// ---- hdl/vrh_bus_if.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// five-channel bus between the two ends
// ----------------------------------------
interface vrh_bus_if;
   logic [vrh_pkg::ID_W-1:0] aw_id;
   logic [vrh_pkg::ADDR_W-1:0] aw_addr;
   logic [vrh_pkg::LEN_W-1:0] aw_len;
   logic aw_valid;
   logic aw_ready;
   logic [vrh_pkg::DATA_W-1:0] w_data;
   logic [vrh_pkg::STRB_W-1:0] w_strb;
   logic w_last;
   logic w_valid;
   logic w_ready;
   logic [vrh_pkg::ID_W-1:0] b_id;
   logic [1:0] b_resp;
   logic b_valid;
   logic b_ready;
   logic [vrh_pkg::ID_W-1:0] ar_id;
   logic [vrh_pkg::ADDR_W-1:0] ar_addr;
   logic [vrh_pkg::LEN_W-1:0] ar_len;
   logic ar_valid;
   logic ar_ready;
   logic [vrh_pkg::ID_W-1:0] r_id;
   logic [vrh_pkg::DATA_W-1:0] r_data;
   logic [1:0] r_resp;
   logic r_last;
   logic r_valid;
   logic r_ready;
   modport mgr (
      output aw_id, aw_addr, aw_len, aw_valid, w_data, w_strb, w_last, w_valid, b_ready,
      output ar_id, ar_addr, ar_len, ar_valid, r_ready,
      input aw_ready, w_ready, b_id, b_resp, b_valid, ar_ready, r_id, r_data, r_resp, r_last, r_valid
   );
   modport sub (
      input aw_id, aw_addr, aw_len, aw_valid, w_data, w_strb, w_last, w_valid, b_ready,
      input ar_id, ar_addr, ar_len, ar_valid, r_ready,
      output aw_ready, w_ready, b_id, b_resp, b_valid, ar_ready, r_id, r_data, r_resp, r_last, r_valid
   );
endinterface : vrh_bus_if

// ---- hdl/vrh_mgr.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// manager end: user command to bus bursts
// ----------------------------------------
module vrh_mgr (
   input wire logic clk_i,
   input wire logic rst_n_i,
   vrh_bus_if.mgr bus,
   input wire logic cmd_valid_i,
   input wire logic cmd_write_i,
   input wire logic [vrh_pkg::ADDR_W-1:0] cmd_addr_i,
   input wire logic [vrh_pkg::LEN_W-1:0] cmd_len_i,
   input wire logic [vrh_pkg::DATA_W-1:0] cmd_data_i,
   input wire logic [vrh_pkg::ID_W-1:0] cmd_id_i,
   output logic cmd_ready_o,
   output logic [vrh_pkg::DATA_W-1:0] rd_data_o,
   output logic rd_valid_o,
   output logic rd_last_o,
   output logic done_o
);
   typedef enum logic [1:0] {MS_IDLE = 2'b00, MS_WR = 2'b01, MS_RESP = 2'b10, MS_RD = 2'b11} vrh_ms_t;
   vrh_ms_t ms_q, ms_d;
   logic aw_v_q, aw_v_d, w_v_q, w_v_d, ar_v_q, ar_v_d;
   logic [vrh_pkg::ADDR_W-1:0] addr_q, addr_d;
   logic [vrh_pkg::LEN_W-1:0] len_q, len_d;
   logic [vrh_pkg::DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
   logic [vrh_pkg::ID_W-1:0] id_q, id_d;
   logic rv_q, rv_d, rl_q, rl_d, dn_q, dn_d;
   logic w_last, w_hs;

   assign w_hs = w_v_q & bus.w_ready;
   vrh_beat_cnt u_wcnt (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .load_i(cmd_ready_o & cmd_valid_i & cmd_write_i),
      .len_i(cmd_len_i),
      .step_i(w_hs),
      .last_o(w_last)
   );

   // outputs from state only, no input paths
   assign bus.aw_valid = aw_v_q;
   assign bus.aw_addr = addr_q;
   assign bus.aw_len = len_q;
   assign bus.aw_id = id_q;
   assign bus.w_valid = w_v_q; // raised with address
   assign bus.w_data = wd_q;
   assign bus.w_strb = w_v_q ? {vrh_pkg::STRB_W{1'b1}} : '0;
   assign bus.w_last = w_last;
   assign bus.b_ready = (ms_q == MS_RESP);
   assign bus.ar_valid = ar_v_q;
   assign bus.ar_addr = addr_q;
   assign bus.ar_len = len_q;
   assign bus.ar_id = id_q;
   assign bus.r_ready = (ms_q == MS_RD);
   assign cmd_ready_o = (ms_q == MS_IDLE);
   assign rd_data_o = rd_q;
   assign rd_valid_o = rv_q;
   assign rd_last_o = rl_q;
   assign done_o = dn_q;

   // ----------------------------------------
   // transaction sequencing
   // ----------------------------------------
   // valids held until taken, never wait ready
   always_comb begin
      ms_d = ms_q;
      aw_v_d = aw_v_q;
      w_v_d = w_v_q;
      ar_v_d = ar_v_q;
      addr_d = addr_q;
      len_d = len_q;
      wd_d = wd_q;
      id_d = id_q;
      rd_d = rd_q;
      rv_d = 1'b0;
      rl_d = 1'b0;
      dn_d = 1'b0;
      unique case (ms_q)
         MS_IDLE: begin
            if (cmd_valid_i) begin
               addr_d = cmd_addr_i;
               len_d = cmd_len_i;
               wd_d = cmd_data_i;
               id_d = cmd_id_i;
               if (cmd_write_i) begin
                  aw_v_d = 1'b1;
                  w_v_d = 1'b1;
                  ms_d = MS_WR;
               end else begin
                  ar_v_d = 1'b1;
                  ms_d = MS_RD;
               end
            end
         end
         MS_WR: begin
            if (aw_v_q && bus.aw_ready) begin
               aw_v_d = 1'b0;
            end
            if (w_hs) begin
               wd_d = wd_q + 32'h1;
               if (w_last) begin
                  w_v_d = 1'b0;
               end
            end
            if (!aw_v_d && !w_v_d) begin
               ms_d = MS_RESP;
            end
         end
         MS_RESP: begin
            if (bus.b_valid) begin
               dn_d = 1'b1;
               ms_d = MS_IDLE;
            end
         end
         MS_RD: begin
            if (ar_v_q && bus.ar_ready) begin
               ar_v_d = 1'b0;
            end
            if (bus.r_valid) begin
               rd_d = bus.r_data;
               rv_d = 1'b1;
               rl_d = bus.r_last;
               if (bus.r_last) begin
                  dn_d = 1'b1;
                  ms_d = MS_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ms_q <= MS_IDLE;
         aw_v_q <= 1'b0;
         w_v_q <= 1'b0;
         ar_v_q <= 1'b0;
         addr_q <= '0;
         len_q <= '0;
         wd_q <= '0;
         id_q <= '0;
         rd_q <= '0;
         rv_q <= 1'b0;
         rl_q <= 1'b0;
         dn_q <= 1'b0;
      end else begin
         ms_q <= ms_d;
         aw_v_q <= aw_v_d;
         w_v_q <= w_v_d;
         ar_v_q <= ar_v_d;
         addr_q <= addr_d;
         len_q <= len_d;
         wd_q <= wd_d;
         id_q <= id_d;
         rd_q <= rd_d;
         rv_q <= rv_d;
         rl_q <= rl_d;
         dn_q <= dn_d;
      end
   end
endmodule : vrh_mgr

// ---- hdl/vrh_pkg.sv ----
// Summary of operation
// - transfer only when valid and ready high
// - no combinational input-to-output paths
// - valid never waits ready, held till taken
// - payload stable while valid waits
// - ready may wait valid, may drop early
// - master address valid held until ready
// - address ready idles high, accepts any address; ar_ready idles low when AR_IDLE_HIGH is 0
// - master write data valid held until ready
// - write ready idles high only if always able
// - master marks final write beat last
// - strobes free while write valid low
// - response valid held until master ready
// - response ready idles high only if able
// - read valid held, only after request
// - read ready idles high only if able
// - slave marks final read beat last
// - write data may precede or match address
// - write data paired with its address
// - read data after address, response after last
// - valid never depends on far ready
// - slave ready may wait for valid
// - response valid only after handshakes done
package vrh_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int ID_W = 4;
   localparam int LEN_W = 4;
   localparam int STRB_W = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] BURST_INCR = 2'h1;
   localparam logic [2:0] SIZE_WORD = 3'h2;
endpackage : vrh_pkg

// ---- hdl/vrh_sub.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// subordinate end: small word memory
// ----------------------------------------
module vrh_sub #(
   parameter int DEPTH = 16,
   parameter bit AR_IDLE_HIGH = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   vrh_bus_if.sub bus,
   output logic [31:0] wr_count_o,
   output logic [31:0] rd_count_o
);
   localparam int IW = $clog2(DEPTH);
   typedef enum logic [1:0] {WS_IDLE = 2'b00, WS_DATA = 2'b01, WS_RESP = 2'b10} vrh_ws_t;
   typedef enum logic [1:0] {RS_IDLE = 2'b00, RS_WAIT = 2'b01, RS_DATA = 2'b10} vrh_rs_t;

   logic [vrh_pkg::DATA_W-1:0] mem_q [DEPTH], mem_d [DEPTH];
   vrh_ws_t ws_q, ws_d;
   vrh_rs_t rs_q, rs_d;
   logic [IW-1:0] wa_q, wa_d, ra_q, ra_d;
   logic [vrh_pkg::ID_W-1:0] wid_q, wid_d, rid_q, rid_d;
   logic [vrh_pkg::LEN_W-1:0] rlen_q, rlen_d;
   logic [vrh_pkg::DATA_W-1:0] rdat_q, rdat_d;
   logic [31:0] wc_q, wc_d, rc_q, rc_d;
   logic aw_hs, w_hs, b_hs, ar_hs, r_hs, r_last;

   // ----------------------------------------
   // handshakes
   // ----------------------------------------
   // ready comes only from state, not inputs
   assign bus.aw_ready = (ws_q == WS_IDLE);
   assign bus.w_ready = (ws_q == WS_DATA);
   assign bus.b_valid = (ws_q == WS_RESP);
   assign bus.ar_ready = AR_IDLE_HIGH ? (rs_q == RS_IDLE) : (rs_q == RS_WAIT);
   assign bus.r_valid = (rs_q == RS_DATA);
   assign aw_hs = bus.aw_valid & bus.aw_ready;
   assign w_hs = bus.w_valid & bus.w_ready;
   assign b_hs = bus.b_valid & bus.b_ready;
   assign ar_hs = bus.ar_valid & bus.ar_ready;
   assign r_hs = bus.r_valid & bus.r_ready;
   assign bus.b_id = wid_q;
   assign bus.b_resp = vrh_pkg::RESP_OKAY;
   assign bus.r_id = rid_q;
   assign bus.r_data = rdat_q;
   assign bus.r_resp = vrh_pkg::RESP_OKAY;
   assign bus.r_last = r_last;
   assign wr_count_o = wc_q;
   assign rd_count_o = rc_q;

   vrh_beat_cnt u_rcnt (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .load_i(ar_hs),
      .len_i(bus.ar_len),
      .step_i(r_hs),
      .last_o(r_last)
   );

   // ----------------------------------------
   // write path
   // ----------------------------------------
   // address first, then data beats, then response
   always_comb begin
      ws_d = ws_q;
      wa_d = wa_q;
      wid_d = wid_q;
      wc_d = wc_q;
      mem_d = mem_q;
      unique case (ws_q)
         WS_IDLE: begin
            if (aw_hs) begin // data held until its address pairs
               wa_d = bus.aw_addr[IW+1:2];
               wid_d = bus.aw_id;
               ws_d = WS_DATA;
            end
         end
         WS_DATA: begin
            if (w_hs) begin
               for (int b = 0; b < vrh_pkg::STRB_W; b++) begin
                  if (bus.w_strb[b]) begin
                     mem_d[wa_q][8*b +: 8] = bus.w_data[8*b +: 8];
                  end
               end
               wa_d = wa_q + 1'b1;
               if (bus.w_last) begin
                  ws_d = WS_RESP;
               end
            end
         end
         WS_RESP: begin
            if (b_hs) begin
               ws_d = WS_IDLE;
               wc_d = wc_q + 32'h1;
            end
         end
         default: ws_d = WS_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ws_q <= WS_IDLE;
         wa_q <= '0;
         wid_q <= '0;
         wc_q <= '0;
      end else begin
         ws_q <= ws_d;
         wa_q <= wa_d;
         wid_q <= wid_d;
         wc_q <= wc_d;
      end
   end

   // storage has no reset
   always_ff @(posedge clk_i) begin
      mem_q <= mem_d;
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   // data only after accepted request
   always_comb begin
      rs_d = rs_q;
      ra_d = ra_q;
      rid_d = rid_q;
      rlen_d = rlen_q;
      rdat_d = rdat_q;
      rc_d = rc_q;
      unique case (rs_q)
         RS_IDLE: begin
            if (AR_IDLE_HIGH) begin
               if (ar_hs) begin
                  ra_d = bus.ar_addr[IW+1:2] + 1'b1;
                  rid_d = bus.ar_id;
                  rdat_d = mem_q[bus.ar_addr[IW+1:2]];
                  rs_d = RS_DATA;
               end
            end else if (bus.ar_valid) begin
               rs_d = RS_WAIT;
            end
         end
         RS_WAIT: begin
            if (ar_hs) begin
               ra_d = bus.ar_addr[IW+1:2] + 1'b1;
               rid_d = bus.ar_id;
               rdat_d = mem_q[bus.ar_addr[IW+1:2]];
               rs_d = RS_DATA;
            end
         end
         RS_DATA: begin
            if (r_hs) begin
               if (r_last) begin
                  rs_d = RS_IDLE;
                  rc_d = rc_q + 32'h1;
               end else begin
                  rdat_d = mem_q[ra_q];
                  ra_d = ra_q + 1'b1;
               end
            end
         end
         default: rs_d = RS_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rs_q <= RS_IDLE;
         ra_q <= '0;
         rid_q <= '0;
         rlen_q <= '0;
         rdat_q <= '0;
         rc_q <= '0;
      end else begin
         rs_q <= rs_d;
         ra_q <= ra_d;
         rid_q <= rid_d;
         rlen_q <= rlen_d;
         rdat_q <= rdat_d;
         rc_q <= rc_d;
      end
   end
endmodule : vrh_sub
